// ### pkg/nfb_pkg.sv
// Package: constants and carriers of the flash bus and command port
package nfb_pkg;
	localparam int NFB_ADDR_W = 24;
	localparam int NFB_PART_W = 3;
	localparam int NFB_PARTS = 8;
	localparam int NFB_BCNT_W = 10;

	// Command codes
	localparam logic [15:0] NFB_CMD_CFG_SETUP = 16'h0060;
	localparam logic [15:0] NFB_CMD_CFG_RCR = 16'h0003;
	localparam logic [15:0] NFB_CMD_CFG_ECR = 16'h0004;
	localparam logic [15:0] NFB_CMD_OTP = 16'h00C0;
	localparam logic [15:0] NFB_CMD_CLR_SR = 16'h0050;
	localparam logic [15:0] NFB_CMD_RD_ARRAY = 16'h00FF;
	localparam logic [15:0] NFB_CMD_RD_STATUS = 16'h0070;
	localparam logic [15:0] NFB_CMD_RD_ID = 16'h0090;
	localparam logic [15:0] NFB_CMD_RD_QUERY = 16'h0098;
	localparam logic [15:0] NFB_CMD_PROG = 16'h0041;
	localparam logic [15:0] NFB_CMD_BUF_SETUP = 16'h00E9;
	localparam logic [15:0] NFB_CMD_CONFIRM = 16'h00D0;

	// Status register
	localparam logic [15:0] NFB_STATUS_RESET = 16'h0080;
	localparam int NFB_SR_READY = 7;
	localparam logic [15:0] NFB_SR_ERR_MASK = 16'h033A;
	localparam logic [15:0] NFB_SR_SEQ_ERR = 16'h0030;
	localparam logic [15:0] NFB_SR_PROG_ERR = 16'h0010;

	// Read configuration register layout
	localparam logic [15:0] NFB_RCR_RESET = 16'hAC0F;
	localparam logic [15:0] NFB_ECR_RESET = 16'h0000;
	localparam int NFB_RCR_MODE = 15;
	localparam int NFB_RCR_LAT_LSB = 11;
	localparam int NFB_RCR_WAIT_POL = 10;
	localparam int NFB_RCR_WRAP = 3;
	localparam logic [2:0] NFB_BL_8 = 3'h1;
	localparam logic [2:0] NFB_BL_16 = 3'h2;
	localparam logic [2:0] NFB_BL_CONT = 3'h7;

	// Identifier offsets
	localparam logic [7:0] NFB_ID_VENDOR_OFS = 8'h00;
	localparam logic [7:0] NFB_ID_DEVICE_OFS = 8'h01;
	localparam logic [7:0] NFB_ID_RCR_OFS = 8'h05;

	typedef enum logic [1:0] {
		NFB_RM_ARRAY = 2'h0,
		NFB_RM_STATUS = 2'h1,
		NFB_RM_ID = 2'h2,
		NFB_RM_QUERY = 2'h3
	} nfb_rmode_t;

	typedef struct packed {
		logic sync_rd;
		logic no_wrap;
		logic wait_hi;
		logic [3:0] lat;
		logic [2:0] blen;
	} nfb_cfg_t;

	typedef struct packed {
		nfb_cfg_t cfg;
		logic arr;
		logic [15:0] info;
	} nfb_xfer_t;

	typedef struct packed {
		logic otp;
		logic [NFB_ADDR_W-1:0] addr;
		logic [15:0] data;
	} nfb_prog_t;
endpackage

// ### core/nfb_flash_port.sv
// Bus interface and command front end of a 16-bit parallel NOR flash
// Functional notes
// - Output enable high with chip select low: data tri-stated, wait deasserted or tri-stated.
// - Read-mode bit one: chip select and output enable low give asynchronous reads.
// - Changing only the four low address bits presents the next word of the page.
// - Read-mode bit zero with select, output enable, address valid low: synchronous burst.
// - Array bursts give first word after latency, then next address each edge.
// - Non-array bursts repeat the same address's word each edge until length reached.
// - Slower parts latch burst address at first clock edge with address valid low.
// - Faster parts latch burst address on last clock edge with address valid low.
// - Burst starts at start address; wrap bit selects wordgroup wrap or continue.
// - Unaligned burst crossing a wordline stalls once, latency minus one, shown on wait.
// - Writes need select and write enable low; sampled at earlier rising edge.
// - Muxed writes take address at address-valid or select rise, data at write rise.
// - Commands are setup plus confirm, or setup plus one data cycle.
// - Reads between setup and confirm leave the pending command untouched.
// - Another write between setup and confirm sets status bits seven, five, four.
// - Setup 0060h with confirm 0003h or 0004h loads config from address bus.
// - Command 00C0h stores the next write's data into the one-time area.
// - Command 0050h clears every status error bit, ready bit untouched.
// - Per-partition read modes: FFh array, 70h status, 90h identifier, 98h query.
// - Program 0041h and buffered 00E9h/00D0h program, partition switches to status.
// - After reset the status register reads 0080h.
// - While reset is low inputs are ignored, outputs tri-stated, programming aborted.
module nfb_flash_port #(
	parameter bit MUXED = 1'b0,
	parameter bit FAST_133 = 1'b0,
	parameter int SG_WORDS = 16,
	parameter int WL_WORDS = 64,
	parameter logic [15:0] VENDOR_ID = 16'h00A5, // Arbitrary value
	parameter logic [15:0] DEVICE_ID = 16'h005A // Arbitrary value
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic bus_clk,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic addr_valid_n,
	input wire logic [nfb_pkg::NFB_ADDR_W-1:0] addr_in,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic dq_oe,
	output logic wait_out,
	output logic wait_oe,
	output logic [nfb_pkg::NFB_ADDR_W-1:0] arr_addr,
	input wire logic [15:0] arr_data,
	input wire logic [15:0] query_data,
	output logic [nfb_pkg::NFB_ADDR_W-1:0] burst_arr_addr,
	input wire logic [15:0] burst_arr_data,
	output nfb_pkg::nfb_prog_t prog_req,
	output logic prog_valid,
	input wire logic array_busy,
	input wire logic prog_fail,
	output logic [15:0] read_config_reg,
	output logic [15:0] ext_config_reg,
	output logic [15:0] status_reg,
	output logic cmd_seq_error
);
	import nfb_pkg::*;

	localparam int AW = NFB_ADDR_W;
	localparam int PIN_W = 4 + AW + 16;
	localparam int XW = $bits(nfb_xfer_t);
	localparam logic [AW-1:0] SG_MASK = AW'(SG_WORDS - 1);
	localparam logic [AW-1:0] WL_MASK = AW'(WL_WORDS - 1);

	if (SG_WORDS < 16 || (SG_WORDS & (SG_WORDS - 1)) != 0 || WL_WORDS < SG_WORDS ||
		(WL_WORDS & (WL_WORDS - 1)) != 0) begin : g_chk
		$error("SG_WORDS and WL_WORDS must be powers of two, SG_WORDS >= 16, WL_WORDS >= SG_WORDS");
	end

	typedef enum logic [6:0] {
		C_IDLE = 7'h01,
		C_CFG = 7'h02,
		C_PROG = 7'h04,
		C_OTP = 7'h08,
		C_BCNT = 7'h10,
		C_BDATA = 7'h20,
		C_BCONF = 7'h40
	} nfb_cstate_t;

	function automatic logic is_rmode_cmd(input logic [15:0] c);
		is_rmode_cmd = (c == NFB_CMD_RD_ARRAY) || (c == NFB_CMD_RD_STATUS) ||
			(c == NFB_CMD_RD_ID) || (c == NFB_CMD_RD_QUERY);
	endfunction

	function automatic nfb_rmode_t rmode_of(input logic [15:0] c);
		unique case (c)
			NFB_CMD_RD_STATUS: rmode_of = NFB_RM_STATUS;
			NFB_CMD_RD_ID: rmode_of = NFB_RM_ID;
			NFB_CMD_RD_QUERY: rmode_of = NFB_RM_QUERY;
			default: rmode_of = NFB_RM_ARRAY;
		endcase
	endfunction

	// ---------------- Pin synchronisers, core domain ----------------
	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic ce_s, oe_s, we_s, adv_s;
	logic [AW-1:0] addr_s;
	logic [15:0] dq_s;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin_s1 <= '1;
			pin_s2 <= '1;
		end else begin
			pin_s1 <= {ce_n, oe_n, we_n, addr_valid_n, addr_in, dq_in};
			pin_s2 <= pin_s1;
		end
	end
	assign {ce_s, oe_s, we_s, adv_s, addr_s, dq_s} = pin_s2;

	// ---------------- Bus cycle decode ----------------
	logic wr_prev;
	logic [AW-1:0] lat_addr;
	wire wr_lvl = !ce_s && !we_s && oe_s;
	// Whichever of select or write enable rises first ends the level
	wire wr_stb = wr_prev && !wr_lvl;
	wire rd_lvl = !ce_s && !oe_s && we_s;
	wire [AW-1:0] bus_addr = MUXED ? {addr_s[AW-1:16], dq_s} : addr_s;
	// Muxed: address frozen when address valid or select rises
	wire [AW-1:0] wr_addr = MUXED ? lat_addr : addr_s;
	wire [15:0] wr_data = dq_s;
	wire [NFB_PART_W-1:0] wr_part = wr_addr[AW-1 -: NFB_PART_W];

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wr_prev <= 1'b0;
			lat_addr <= '0;
		end else begin
			wr_prev <= wr_lvl;
			if (!ce_s && !adv_s)
				lat_addr <= bus_addr;
		end
	end

	// ---------------- Command sequencer ----------------
	nfb_cstate_t cst, next_cst;
	logic [NFB_BCNT_W-1:0] bcnt, next_bcnt;
	logic seq_err, prog_fire, prog_otp, rcr_ld, ecr_ld, clr_err, rm_ld;
	nfb_rmode_t rm_val;

	always_comb begin
		next_cst = cst;
		next_bcnt = bcnt;
		seq_err = 1'b0;
		prog_fire = 1'b0;
		prog_otp = 1'b0;
		rcr_ld = 1'b0;
		ecr_ld = 1'b0;
		clr_err = 1'b0;
		rm_ld = 1'b0;
		rm_val = NFB_RM_ARRAY;
		// Only write strobes move the sequencer; reads pass through untouched
		if (wr_stb) begin
			unique case (cst)
				C_IDLE: begin
					rm_ld = is_rmode_cmd(wr_data);
					rm_val = rmode_of(wr_data);
					if (wr_data == NFB_CMD_CFG_SETUP)
						next_cst = C_CFG;
					else if (wr_data == NFB_CMD_PROG)
						next_cst = C_PROG;
					else if (wr_data == NFB_CMD_OTP)
						next_cst = C_OTP;
					else if (wr_data == NFB_CMD_BUF_SETUP)
						next_cst = C_BCNT;
					else if (wr_data == NFB_CMD_CLR_SR)
						clr_err = 1'b1;
				end
				C_CFG: begin
					next_cst = C_IDLE;
					rcr_ld = wr_data == NFB_CMD_CFG_RCR;
					ecr_ld = wr_data == NFB_CMD_CFG_ECR;
					seq_err = !(rcr_ld || ecr_ld);
				end
				C_PROG: begin
					next_cst = C_IDLE;
					prog_fire = 1'b1;
					rm_ld = 1'b1;
					rm_val = NFB_RM_STATUS;
				end
				C_OTP: begin
					next_cst = C_IDLE;
					prog_fire = 1'b1;
					prog_otp = 1'b1;
				end
				C_BCNT: begin
					next_cst = C_BDATA;
					next_bcnt = wr_data[NFB_BCNT_W-1:0];
				end
				C_BDATA: begin
					prog_fire = 1'b1;
					if (bcnt == '0)
						next_cst = C_BCONF;
					else
						next_bcnt = bcnt - 1'b1;
				end
				C_BCONF: begin
					next_cst = C_IDLE;
					rm_ld = 1'b1;
					rm_val = NFB_RM_STATUS;
					seq_err = wr_data != NFB_CMD_CONFIRM;
				end
				default: next_cst = C_IDLE;
			endcase
		end
	end

	// ---------------- Registers and status ----------------
	nfb_rmode_t rmode [NFB_PARTS];
	wire [15:0] err_keep = status_reg & NFB_SR_ERR_MASK & ~(clr_err ? NFB_SR_ERR_MASK : 16'h0000);
	// Set after clear, so an error in the clearing cycle survives
	wire [15:0] err_set = (seq_err ? NFB_SR_SEQ_ERR : 16'h0000) | (prog_fail ? NFB_SR_PROG_ERR : 16'h0000);
	wire [15:0] ready_bit = array_busy ? 16'h0000 : 16'h0080;
	wire [15:0] next_status = err_keep | err_set | ready_bit;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cst <= C_IDLE;
			bcnt <= '0;
			status_reg <= NFB_STATUS_RESET;
			read_config_reg <= NFB_RCR_RESET;
			ext_config_reg <= NFB_ECR_RESET;
			prog_valid <= 1'b0;
			prog_req <= '0;
			cmd_seq_error <= 1'b0;
			for (int i = 0; i < NFB_PARTS; i++)
				rmode[i] <= NFB_RM_ARRAY;
		end else begin
			cst <= next_cst;
			bcnt <= next_bcnt;
			status_reg <= next_status;
			cmd_seq_error <= seq_err;
			prog_valid <= prog_fire;
			prog_req <= prog_fire ? '{otp: prog_otp, addr: wr_addr, data: wr_data} : prog_req;
			if (rcr_ld)
				read_config_reg <= wr_addr[15:0];
			if (ecr_ld)
				ext_config_reg <= wr_addr[15:0];
			if (rm_ld)
				rmode[wr_part] <= rm_val;
		end
	end

	// ---------------- Asynchronous read path ----------------
	nfb_rmode_t rd_mode;
	logic [15:0] id_word, info_word, rd_word;
	logic out_on, ce_on;
	assign rd_mode = rmode[lat_addr[AW-1 -: NFB_PART_W]];
	assign id_word = (lat_addr[7:0] == NFB_ID_VENDOR_OFS) ? VENDOR_ID :
		(lat_addr[7:0] == NFB_ID_DEVICE_OFS) ? DEVICE_ID :
		(lat_addr[7:0] == NFB_ID_RCR_OFS) ? read_config_reg : 16'h0000;
	assign info_word = (rd_mode == NFB_RM_STATUS) ? status_reg :
		(rd_mode == NFB_RM_ID) ? id_word : query_data;
	assign arr_addr = lat_addr;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rd_word <= '0;
			out_on <= 1'b0;
			ce_on <= 1'b0;
		end else begin
			// Low address bits take the same registered path as the rest, so a page step takes as long as a first access
			rd_word <= (rd_mode == NFB_RM_ARRAY) ? arr_data : info_word;
			out_on <= rd_lvl;
			ce_on <= !ce_s;
		end
	end

	// ---------------- Crossing into the link domain ----------------
	nfb_cfg_t cfg;
	nfb_xfer_t xfer_l1, xfer_l2;
	logic lrst_s1, lrst_n;
	assign cfg = '{sync_rd: !read_config_reg[NFB_RCR_MODE], no_wrap: read_config_reg[NFB_RCR_WRAP],
		wait_hi: read_config_reg[NFB_RCR_WAIT_POL],
		lat: read_config_reg[NFB_RCR_LAT_LSB +: 4], blen: read_config_reg[2:0]};

	// Reset asserts at once, releases on the link clock
	always_ff @(posedge bus_clk or negedge nrst) begin
		if (!nrst) begin
			lrst_s1 <= 1'b0;
			lrst_n <= 1'b0;
		end else begin
			lrst_s1 <= 1'b1;
			lrst_n <= lrst_s1;
		end
	end

	// Configuration and info word are quasi-static during a burst, so a
	// two-stage level crossing suffices; they settle during the latency
	always_ff @(posedge bus_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			xfer_l1 <= '0;
			xfer_l2 <= '0;
		end else begin
			xfer_l1 <= '{cfg: cfg, arr: rd_mode == NFB_RM_ARRAY, info: info_word};
			xfer_l2 <= xfer_l1;
		end
	end

	// ---------------- Burst engine, link domain ----------------
	nfb_cfg_t lcfg;
	logic adv_prev, run, eowl_done, unaligned, first_pend;
	logic [3:0] lat_cnt, stall_cnt;
	logic [4:0] beats;
	logic [AW-1:0] cur;
	logic [15:0] dq_l;
	assign lcfg = xfer_l2.cfg;

	wire [AW-1:0] link_addr = MUXED ? {addr_in[AW-1:16], dq_in} : addr_in;
	// Slow parts take the first edge low; fast parts keep taking until the last
	wire ld = !ce_n && !addr_valid_n && (FAST_133 || adv_prev);
	wire [3:0] lat_m1 = (lcfg.lat == 4'h0) ? 4'h0 : lcfg.lat - 4'h1;
	wire cont = (lcfg.blen != NFB_BL_8) && (lcfg.blen != NFB_BL_16);
	wire [4:0] blen_words = (lcfg.blen == NFB_BL_8) ? 5'h08 : 5'h10;
	wire [AW-1:0] gmask = (lcfg.blen == NFB_BL_8) ? AW'(7) : AW'(15);
	wire wrap_on = !lcfg.no_wrap && !cont;
	wire beat = run && !ld && lat_cnt == 4'h0 && stall_cnt == 4'h0 && (cont || beats != 5'h00);
	wire [AW-1:0] seq_addr = cur + 1'b1;
	wire [AW-1:0] wrap_addr = (cur & ~gmask) | (seq_addr & gmask);
	wire [AW-1:0] adv_addr = wrap_on ? wrap_addr : seq_addr;
	wire wl_cross = !wrap_on && (seq_addr & WL_MASK) == '0;
	wire hit_eowl = beat && xfer_l2.arr && unaligned && !eowl_done && wl_cross;
	// Held until the first word is really on the pins, not only until the count ends
	wire link_wait = run && (lat_cnt != 4'h0 || stall_cnt != 4'h0 || first_pend);

	wire [3:0] next_lat = ld ? lat_m1 : (lat_cnt != 4'h0) ? lat_cnt - 4'h1 : 4'h0;
	wire [3:0] next_stall = hit_eowl ? lat_m1 : (stall_cnt != 4'h0) ? stall_cnt - 4'h1 : 4'h0;
	wire [4:0] next_beats = ld ? blen_words : (beat && !cont) ? beats - 5'h01 : beats;
	// Non-array bursts hold the address and so repeat the same word
	wire [AW-1:0] next_cur = ld ? link_addr : (beat && xfer_l2.arr) ? adv_addr : cur;
	wire next_run = ld ? 1'b1 : ce_n ? 1'b0 : run;

	always_ff @(posedge bus_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			adv_prev <= 1'b1;
			run <= 1'b0;
			lat_cnt <= 4'h0;
			stall_cnt <= 4'h0;
			beats <= 5'h00;
			cur <= '0;
			eowl_done <= 1'b0;
			unaligned <= 1'b0;
			first_pend <= 1'b0;
			dq_l <= 16'h0000;
		end else begin
			adv_prev <= addr_valid_n;
			run <= next_run;
			lat_cnt <= next_lat;
			stall_cnt <= next_stall;
			beats <= next_beats;
			cur <= next_cur;
			eowl_done <= ld ? 1'b0 : (eowl_done || hit_eowl);
			unaligned <= ld ? (link_addr & SG_MASK) != '0 : unaligned;
			first_pend <= ld ? 1'b1 : beat ? 1'b0 : first_pend;
			if (beat)
				dq_l <= xfer_l2.arr ? burst_arr_data : xfer_l2.info;
		end
	end
	assign burst_arr_addr = cur;

	// ---------------- Pins ----------------
	// Read-mode bit picks which domain's word reaches the pins
	wire sync_rd = cfg.sync_rd;
	wire wait_act = out_on && sync_rd && link_wait;
	assign dq_out = sync_rd ? dq_l : rd_word;
	assign dq_oe = out_on;
	assign wait_out = cfg.wait_hi ? wait_act : !wait_act;
	// Muxed parts keep driving wait, deasserted, while selected
	assign wait_oe = MUXED ? ce_on : out_on;
endmodule

// ### verification/nfb_port_checker.sv
// Checker: port-level assertions of the flash bus front end
module nfb_port_checker #(
	parameter bit MUXED = 1'b0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic bus_clk,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic addr_valid_n,
	input wire logic dq_oe,
	input wire logic wait_out,
	input wire logic wait_oe,
	input wire logic prog_valid,
	input wire logic array_busy,
	input wire logic [15:0] read_config_reg,
	input wire logic [15:0] status_reg,
	input wire logic cmd_seq_error
);
	timeunit 1ns;
	timeprecision 100ps;
	import nfb_pkg::*;

	AST_RST_STATE: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(nrst) |-> status_reg == 16'h0080 && !dq_oe && !wait_oe && read_config_reg == 16'hAC0F)
		else $error("reset state wrong");
	AST_OE_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
		oe_n [*5] |-> !dq_oe)
		else $error("data driven with output enable high");
	AST_CE_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce_n [*5] |-> !dq_oe && !wait_oe)
		else $error("outputs driven while deselected");
	AST_WAIT_OE: assert property (@(posedge ref_clk) disable iff (!nrst)
		!MUXED |-> wait_oe == dq_oe)
		else $error("wait enable differs from data enable");
	AST_SEQ_ERR: assert property (@(posedge ref_clk) disable iff (!nrst)
		cmd_seq_error |-> ##[0:2] (status_reg[5] && status_reg[4]))
		else $error("sequence error not flagged in status");
	AST_BUSY: assert property (@(posedge ref_clk) disable iff (!nrst)
		array_busy [*3] |-> !status_reg[7])
		else $error("ready bit set while array busy");
	AST_PROG_PULSE: assert property (@(posedge ref_clk) disable iff (!nrst)
		prog_valid |=> !prog_valid)
		else $error("program request longer than one cycle");
	AST_WR_OE_LOW: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!oe_n) [*6] |-> !prog_valid && !cmd_seq_error)
		else $error("write taken with output enable low");
	AST_BURST_WAIT: assert property (@(posedge bus_clk) disable iff (!nrst)
		!ce_n && !addr_valid_n && $past(addr_valid_n) && !read_config_reg[15] && read_config_reg[10]
		|=> wait_out)
		else $error("wait not active after burst latch");
endmodule

bind nfb_flash_port nfb_port_checker #(.MUXED(MUXED)) u_chk (.ref_clk(ref_clk), .nrst(nrst),
	.bus_clk(bus_clk), .ce_n(ce_n), .oe_n(oe_n), .addr_valid_n(addr_valid_n), .dq_oe(dq_oe),
	.wait_out(wait_out), .wait_oe(wait_oe), .prog_valid(prog_valid), .array_busy(array_busy),
	.read_config_reg(read_config_reg), .status_reg(status_reg), .cmd_seq_error(cmd_seq_error));

// ### verification/nfb_array_model.sv
// Array side model: words, query data and busy after a program request
module nfb_array_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [nfb_pkg::NFB_ADDR_W-1:0] arr_addr,
	output logic [15:0] arr_data,
	output logic [15:0] query_data,
	input wire logic [nfb_pkg::NFB_ADDR_W-1:0] burst_arr_addr,
	output logic [15:0] burst_arr_data,
	input wire logic prog_valid,
	output logic array_busy,
	output logic prog_fail
);
	timeunit 1ns;
	timeprecision 100ps;
	import nfb_pkg::*;
	logic [2:0] busy_cnt;

	assign arr_data = arr_addr[15:0] ^ 16'hC3A5;
	assign burst_arr_data = burst_arr_addr[15:0] ^ 16'hC3A5;
	assign query_data = ~arr_addr[15:0];
	assign prog_fail = 1'b0;
	assign array_busy = busy_cnt != 3'h0;
	// Reset drops any program in flight
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			busy_cnt <= 3'h0;
		else if (prog_valid)
			busy_cnt <= 3'h4;
		else if (busy_cnt != 3'h0)
			busy_cnt <= busy_cnt - 3'h1;
	end
endmodule

// ### verification/tb_nor_flash_bus_and_command_port.sv
// Testbench: host bus cycles, command sequences and bursts
module tb_nor_flash_bus_and_command_port;
	timeunit 1ns;
	timeprecision 100ps;
	import nfb_pkg::*;
	localparam logic [15:0] VID = 16'h1357; // Arbitrary value
	localparam logic [15:0] DID = 16'h2468; // Arbitrary value
	localparam logic [23:0] P1 = 24'h200000;
	logic ref_clk = 0, nrst = 0, bus_clk = 0, bclk_en = 1;
	logic ce_n = 1, oe_n = 1, we_n = 1, addr_valid_n = 1;
	logic [23:0] addr_in = 24'h0, arr_addr, burst_arr_addr;
	logic [15:0] dq_in = 16'h0, dq_out, arr_data, query_data, burst_arr_data;
	logic [15:0] read_config_reg, ext_config_reg, status_reg;
	logic dq_oe, wait_out, wait_oe, prog_valid, array_busy, prog_fail, cmd_seq_error;
	nfb_prog_t prog_req, pq;
	int n_mismatch = 0, total_checks = 0, n_seq = 0, n_prog = 0, cyc = 0;

	nfb_flash_port #(.VENDOR_ID(VID), .DEVICE_ID(DID)) dut (.ref_clk, .nrst, .bus_clk, .ce_n, .oe_n,
		.we_n, .addr_valid_n, .addr_in, .dq_in, .dq_out, .dq_oe, .wait_out, .wait_oe, .arr_addr,
		.arr_data, .query_data, .burst_arr_addr, .burst_arr_data, .prog_req, .prog_valid,
		.array_busy, .prog_fail, .read_config_reg, .ext_config_reg, .status_reg, .cmd_seq_error);
	nfb_array_model u_arr (.ref_clk, .nrst, .arr_addr, .arr_data, .query_data, .burst_arr_addr,
		.burst_arr_data, .prog_valid, .array_busy, .prog_fail);

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Link clock stands still outside bursts
	initial begin
		#3;
		forever #15 bus_clk = bclk_en ? ~bus_clk : 1'b0;
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cmd_seq_error === 1'b1)
			n_seq++;
		if (prog_valid === 1'b1) begin
			n_prog++;
			pq = prog_req;
		end
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [15:0] aw(input logic [23:0] a);
		return a[15:0] ^ 16'hC3A5;
	endfunction

	// Output enable rises first, then select toggles before the write
	task automatic wr(input logic [23:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		oe_n = 1;
		repeat (4) @(negedge ref_clk);
		ce_n = 1;
		repeat (4) @(negedge ref_clk);
		addr_in = a;
		dq_in = d;
		ce_n = 0;
		we_n = 0;
		repeat (4) @(negedge ref_clk);
		we_n = 1;
		ce_n = 1;
		repeat (6) @(negedge ref_clk);
	endtask

	// Read stays open; a later call only moves the address
	task automatic rd(input logic [23:0] a, input logic [15:0] e, input string nm);
		@(negedge ref_clk);
		addr_in = a;
		ce_n = 0;
		oe_n = 0;
		// Address valid held low so the address flows through
		addr_valid_n = 0;
		repeat (6) @(negedge ref_clk);
		chk("dq_oe", 1'b1, dq_oe);
		chk(nm, e, dq_out);
	endtask

	// Clock runs a few edges first so link reset and configuration settle
	task automatic burst(input logic [23:0] a, input logic arr, input logic wrp, input int n, input int waits);
		logic [15:0] e;
		int idx;
		int nw;
		idx = 0;
		nw = 0;
		@(negedge ref_clk);
		addr_valid_n = 1;
		bclk_en = 1;
		repeat (4) @(posedge bus_clk);
		@(negedge ref_clk);
		addr_in = a;
		ce_n = 0;
		oe_n = 0;
		addr_valid_n = 0;
		@(posedge bus_clk);
		@(negedge bus_clk);
		addr_valid_n = 1;
		for (int k = 1; k <= n; k++) begin
			@(posedge bus_clk);
			#2;
			if (k < 3)
				chk("wait_on", 1'b1, wait_out);
			else if (k > 3 && wait_out === 1'b1)
				nw++;
			else begin
				e = !arr ? 16'h0080 : wrp ? aw({a[23:3], a[2:0] + 3'(idx)}) : aw(a + 24'(idx));
				chk("burst", e, dq_out);
				idx++;
			end
			if (k == 3)
				chk("wait_off", 1'b0, wait_out);
		end
		chk("stall_waits", 24'(waits), 24'(nw));
		@(negedge ref_clk);
		ce_n = 1;
		oe_n = 1;
		bclk_en = 0;
	endtask

	initial begin
		repeat (5) @(negedge ref_clk);
		nrst = 1;
		bclk_en = 0;
		repeat (4) @(negedge ref_clk);
		chk("status", 16'h0080, status_reg);
		chk("rcr", 16'hAC0F, read_config_reg);
		chk("dq_oe_rst", 1'b0, dq_oe);
		rd(24'h000123, aw(24'h000123), "array");
		// Only the low four bits move within the page
		rd(24'h000120, aw(24'h000120), "page");
		rd(24'h00012F, aw(24'h00012F), "page");
		@(negedge ref_clk);
		oe_n = 1;
		repeat (6) @(negedge ref_clk);
		chk("oe_off", 1'b0, dq_oe);
		chk("wait_oe_off", 1'b0, wait_oe);
		wr(P1, NFB_CMD_RD_STATUS);
		rd(P1, 16'h0080, "p1_status");
		rd(24'h000007, aw(24'h000007), "p0_array");
		wr(P1, NFB_CMD_RD_ID);
		rd(P1, VID, "vendor");
		rd(P1 + 24'h1, DID, "device");
		rd(P1 + 24'h5, 16'hAC0F, "id_rcr");
		wr(P1, NFB_CMD_RD_QUERY);
		rd(P1 + 24'h7, ~16'h0007, "query");
		wr(P1, NFB_CMD_RD_ARRAY);
		rd(P1 + 24'h7, aw(P1 + 24'h7), "p1_array");
		wr(24'h0, NFB_CMD_CFG_SETUP);
		rd(24'h000003, aw(24'h000003), "mid_read");
		wr(24'h00A40F, NFB_CMD_CFG_RCR);
		chk("rcr_new", 16'hA40F, read_config_reg);
		wr(24'h001234, NFB_CMD_CFG_SETUP);
		wr(24'h001234, NFB_CMD_CFG_ECR);
		chk("ecr", 16'h1234, ext_config_reg);
		wr(24'h0, NFB_CMD_CFG_SETUP);
		wr(24'h0, NFB_CMD_RD_STATUS);
		chk("seq_pulse", 24'h000001, 24'(n_seq));
		chk("seq_bits", 16'h00B0, status_reg & 16'h00B0);
		wr(24'h0, NFB_CMD_CLR_SR);
		chk("cleared", 16'h0080, status_reg);
		wr(24'h000040, NFB_CMD_PROG);
		wr(24'h000040, 16'hBEEF);
		chk("prog_addr", 24'h000040, pq.addr);
		chk("prog_data", 16'hBEEF, pq.data);
		chk("prog_otp", 1'b0, pq.otp);
		rd(24'h000040, 16'h0080, "prog_status");
		wr(24'h000100, NFB_CMD_OTP);
		wr(24'h000100, 16'h0F0F);
		chk("otp_flag", 1'b1, pq.otp);
		chk("otp_data", 16'h0F0F, pq.data);
		wr(24'h0, NFB_CMD_RD_ARRAY);
		wr(24'h0, NFB_CMD_BUF_SETUP);
		wr(24'h0, 16'h0001);
		wr(24'h000002, 16'h1111);
		wr(24'h000003, 16'h2222);
		wr(24'h0, NFB_CMD_CONFIRM);
		chk("buf_words", 24'h000004, 24'(n_prog));
		chk("buf_no_err", 24'h000001, 24'(n_seq));
		rd(24'h000003, 16'h0080, "buf_status");
		wr(24'h0, NFB_CMD_RD_ARRAY);
		// Synchronous mode, latency 3, wait active high, no wrap, length 16
		wr(24'h0, NFB_CMD_CFG_SETUP);
		wr(24'h001C0A, NFB_CMD_CFG_RCR);
		burst(24'h000020, 1'b1, 1'b0, 6, 0);
		// Unaligned start crossing a wordline stalls once, latency minus one
		burst(24'h00003D, 1'b1, 1'b0, 9, 2);
		// Wrap on, length 8
		wr(24'h0, NFB_CMD_CFG_SETUP);
		wr(24'h001C01, NFB_CMD_CFG_RCR);
		burst(24'h000026, 1'b1, 1'b1, 8, 0);
		wr(24'h0, NFB_CMD_RD_STATUS);
		burst(24'h000020, 1'b0, 1'b0, 6, 0);
		end_of_test();
	end
endmodule
